// ===== logic/sep_bus_if.sv
// sep_bus_if.sv: the two-wire bus joining the eeprom end and the master end
// assumes: open-drain wires resolved here, pulled up when nobody pulls low
`timescale 1ns/10ps
`default_nettype none
interface sep_bus_if;
  logic sclMasterOut;
  logic sclMasterOe_n;
  logic sdaMasterOut;
  logic sdaMasterOe_n;
  logic sdaSlaveOut;
  logic sdaSlaveOe_n;
  logic scl;
  logic sda;
  // wired-and with pull-up
  assign scl = sclMasterOe_n | sclMasterOut;
  assign sda = (sdaMasterOe_n | sdaMasterOut) & (sdaSlaveOe_n | sdaSlaveOut);
  modport eeprom (input scl, input sda, output sdaSlaveOut, output sdaSlaveOe_n);
  modport master (input scl, input sda, output sclMasterOut, output sclMasterOe_n,
                  output sdaMasterOut, output sdaMasterOe_n);
endinterface
`default_nettype wire

// ===== logic/sep_eeprom.sv
// sep_eeprom.sv: eeprom end, read path plus the shared pointer with write path
// assumes: bus via sep_bus_if; memory in flip-flops; clk far faster than scl
//
// Contract
// R1 - one pointer tracks last accessed location
// R2 - on read, shift byte n, then n+1
// R3 - nack then stop ends read output
// R4 - read increments full pointer after bit 8
// R5 - writes roll only low four pointer bits
// R6 - dummy write loads word address into pointer
// R7 - master restarts with read for random read
// R8 - master ack gets next byte, unlimited
// R9 - pointer wraps from top to zero
// R10 - low supply at stop cancels write
// R11 - no reset pin; start then stop idles (sep_eeprom still has an rst_n input)
// R12 - master resyncs: start, 9 clocks, start, stop
// R13 - released sda at dummy clocks frees line
// R14 - start discards command, expects address
// R15 - master starts right after dummy clocks
// R16 - resync recommended at system start
// R17 - master checks every acknowledge
// R18 - sda driven low only, never high
// R19 - start/stop only while scl high
// R20 - type code plus three select pins match
// R21 - no acknowledge during write cycle
// R22 - stop during read goes standby
// R23 - pointer width follows memory size
`timescale 1ns/10ps
`default_nettype none
`include "sep_regs.svh"
module sep_eeprom #(
  parameter int ADDR_W    = 8,
  parameter int WRITE_CYC = `SEP_WRITE_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  sep_bus_if.eeprom bus,
  input  wire logic addr_select_bit0_pin,
  input  wire logic addr_select_bit1_pin,
  input  wire logic addr_select_bit2_pin,
  input  wire logic lowSupply,
  input  wire logic writeProtect,
  output logic      writeBusy,
  output logic      writeCancelled
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PG    = `SEP_PAGE_BITS;

  typedef enum logic [2:0] {ST_IDLE, ST_DEVADDR, ST_WORDADDR, ST_WDATA, ST_READ, ST_READACK} sep_state_t;

  logic sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen;
  sep_line_sync uSync (
    .clk       (clk),
    .rst_n     (rst_n),
    .sclIn     (bus.scl),
    .sdaIn     (bus.sda),
    .sclLevel  (sclLevel),
    .sdaLevel  (sdaLevel),
    .sclRise   (sclRise),
    .sclFall   (sclFall),
    .startSeen (startSeen),
    .stopSeen  (stopSeen)
  );

  sep_state_t          state_q;
  logic [3:0]          bitCnt_q;
  logic [7:0]          shift_q;
  logic [ADDR_W-1:0]   ptr_q;                 // [R23]
  logic [7:0]          mem_q [DEPTH];
  logic [7:0]          wbuf_q [1<<PG];
  logic [PG:0]         wCount_q;
  logic [ADDR_W-1:0]   wBase_q;
  logic                ackDrive_q;
  logic                sdaLow_q;
  logic [31:0]         busyCnt_q;
  logic                busy_q;
  logic                cancel_q;
  logic                wp_q;
  logic                byteDone;
  logic                devMatch;

  // pins come from outside clk: two flops before use
  logic [4:0]          pinMeta_q;
  logic [4:0]          pinSync_q;
  always_ff @(posedge clk) begin
    pinMeta_q <= {writeProtect, lowSupply, addr_select_bit2_pin, addr_select_bit1_pin, addr_select_bit0_pin};
    pinSync_q <= pinMeta_q;
  end

  assign byteDone = sclRise & (bitCnt_q == 4'h7);
  assign devMatch = (shift_q[7:4] == `SEP_TYPE_CODE) && (shift_q[3:1] == pinSync_q[2:0]); // [R20]

  function automatic logic [ADDR_W-1:0] pageNext(input logic [ADDR_W-1:0] a);
    pageNext = {a[ADDR_W-1:PG], a[PG-1:0] + 1'b1};                                                        // [R5]
  endfunction

  // ==========================================================
  // protocol state machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      ackDrive_q <= 1'b0;
      wCount_q   <= '0;
    end else if (startSeen) begin
      state_q    <= ST_DEVADDR;                                                                          // [R14]
      bitCnt_q   <= 4'h0;
      ackDrive_q <= 1'b0;
      wCount_q   <= '0;
    end else if (stopSeen) begin
      state_q    <= ST_IDLE;                                                                             // [R11] [R22] [R3]
      ackDrive_q <= 1'b0;
    end else begin
      // count 9 marks the ninth clock; its falling edge closes the byte
      if (sclFall && bitCnt_q == 4'h9)
        bitCnt_q <= 4'h0;
      else if (sclRise)
        bitCnt_q <= bitCnt_q + 4'h1;
      // ack slot ends at the falling edge after the ninth clock
      if (sclFall && bitCnt_q == 4'h9) begin
        ackDrive_q <= 1'b0;
        if (state_q == ST_READ && ackDrive_q == 1'b0)
          shift_q <= mem_q[ptr_q];
      end
      case (state_q)
        ST_IDLE: ;
        ST_DEVADDR, ST_WORDADDR, ST_WDATA: begin
          if (sclRise && bitCnt_q < 4'h8)
            shift_q <= {shift_q[6:0], sdaLevel};
          if (sclFall && bitCnt_q == 4'h8 && ackDrive_q == 1'b0) begin
            // 8 bits in: decide on the ack slot
          end
          if (sclFall && bitCnt_q == 4'h8 && !ackDrive_q) begin
            if (state_q == ST_DEVADDR) begin
              if (devMatch && !busy_q) begin                                                             // [R21]
                ackDrive_q <= 1'b1;
                state_q    <= shift_q[0] ? ST_READ : ST_WORDADDR;
                if (shift_q[0])
                  shift_q <= mem_q[ptr_q];                                                               // [R2]
              end else
                state_q <= ST_IDLE;
            end else if (state_q == ST_WORDADDR) begin
              ackDrive_q <= 1'b1;                                                                        // [R6]
              state_q    <= ST_WDATA;
            end else begin
              ackDrive_q <= ~wp_q;
              // refused bytes must not start a write cycle
              wCount_q   <= (wCount_q[PG] || wp_q) ? wCount_q : wCount_q + 1'b1;
            end
          end
        end
        ST_READ: begin
          if (sclFall && bitCnt_q < 4'h8 && bitCnt_q != 4'h0)
            shift_q <= {shift_q[6:0], 1'b1};
          if (sclRise && bitCnt_q == 4'h8)
            state_q <= sdaLevel ? ST_IDLE : ST_READ;                                                     // [R8] [R3]
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // sda pull-down: only ever low or released
  always_ff @(posedge clk) begin
    if (!rst_n)
      sdaLow_q <= 1'b0;
    else if (startSeen || stopSeen)
      sdaLow_q <= 1'b0;
    else if (sclFall) begin
      if (state_q == ST_READ && bitCnt_q == 4'h9)
        sdaLow_q <= ~mem_q[ptr_q][7];
      else if (state_q == ST_READ && bitCnt_q < 4'h8 && bitCnt_q != 4'h0)
        sdaLow_q <= ~shift_q[6];
      else if (bitCnt_q == 4'h8 && !ackDrive_q &&
               ((state_q == ST_DEVADDR && devMatch && !busy_q) || state_q == ST_WORDADDR ||
                (state_q == ST_WDATA && !wp_q)))
        sdaLow_q <= 1'b1;
      else
        sdaLow_q <= 1'b0;                                                                                // [R13]
    end
  end
  assign bus.sdaSlaveOut  = 1'b0;                                                                        // [R18]
  assign bus.sdaSlaveOe_n = ~sdaLow_q;

  // ==========================================================
  // shared pointer and page buffer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_q   <= '0;
      wBase_q <= '0;
    end else if (!startSeen && !stopSeen) begin
      if (state_q == ST_WORDADDR && byteDone) begin
        ptr_q   <= {shift_q[ADDR_W-2:0], sdaLevel};                                                      // [R6] [R1]
        wBase_q <= {shift_q[ADDR_W-2:0], sdaLevel};
      end else if (state_q == ST_WDATA && byteDone && !wp_q)
        ptr_q <= pageNext(ptr_q);                                                                        // [R5] [R1]
      else if (state_q == ST_READ && byteDone)
        ptr_q <= ptr_q + 1'b1;                                                                           // [R4] [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (state_q == ST_WDATA && byteDone && !wp_q)
      wbuf_q[ptr_q[PG-1:0]] <= {shift_q[6:0], sdaLevel};
  end

  // ==========================================================
  // write cycle: started by stop after data, cancelled on low supply
  always_ff @(posedge clk) begin
    if (!rst_n)
      wp_q <= 1'b0;
    else if (startSeen)
      wp_q <= pinSync_q[4];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q    <= 1'b0;
      busyCnt_q <= 32'h0;
      cancel_q  <= 1'b0;
    end else if (stopSeen && state_q == ST_WDATA && wCount_q != '0 && !busy_q) begin
      cancel_q <= pinSync_q[3];                                                                          // [R10]
      busy_q   <= ~pinSync_q[3];
      busyCnt_q <= 32'h0;
    end else if (busy_q) begin
      busyCnt_q <= busyCnt_q + 32'h1;
      if (busyCnt_q == 32'(WRITE_CYC - 1))
        busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (busy_q && busyCnt_q == 32'h0) begin
      for (int i = 0; i < (1 << PG); i++)
        if (i < wCount_q)
          mem_q[{wBase_q[ADDR_W-1:PG], wBase_q[PG-1:0] + PG'(i)}] <= wbuf_q[wBase_q[PG-1:0] + PG'(i)];
    end
  end

  assign writeBusy      = busy_q;
  assign writeCancelled = cancel_q;
endmodule
`default_nettype wire

// ===== logic/sep_line_sync.sv
// sep_line_sync.sv: two-flop synchroniser and edge finder for scl and sda
// assumes: lines are asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module sep_line_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sclLevel,
  output logic      sdaLevel,
  output logic      sclRise,
  output logic      sclFall,
  output logic      startSeen,
  output logic      stopSeen
);
  logic [1:0] sclMeta_q;
  logic [1:0] sdaMeta_q;
  logic       sclOld_q;
  logic       sdaOld_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclMeta_q <= 2'h3;
      sdaMeta_q <= 2'h3;
      sclOld_q  <= 1'b1;
      sdaOld_q  <= 1'b1;
    end else begin
      sclMeta_q <= {sclMeta_q[0], sclIn};
      sdaMeta_q <= {sdaMeta_q[0], sdaIn};
      sclOld_q  <= sclMeta_q[1];
      sdaOld_q  <= sdaMeta_q[1];
    end
  end

  assign sclLevel  = sclMeta_q[1];
  assign sdaLevel  = sdaMeta_q[1];
  assign sclRise   = sclMeta_q[1] & ~sclOld_q;
  assign sclFall   = ~sclMeta_q[1] & sclOld_q;
  // sda moving while scl stays high
  assign startSeen = sclOld_q & sclMeta_q[1] & sdaOld_q & ~sdaMeta_q[1]; // [R19]
  assign stopSeen  = sclOld_q & sclMeta_q[1] & ~sdaOld_q & sdaMeta_q[1];
endmodule
`default_nettype wire

// ===== logic/sep_master.sv
// sep_master.sv: bus master end; issues reads, dummy writes and resync
// assumes: user holds cmd stable while cmdValid until cmdReady pulses
`timescale 1ns/10ps
`default_nettype none
`include "sep_regs.svh"
module sep_master #(
  parameter int HALF = `SEP_SCL_HALF
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  sep_bus_if.master         bus,
  input  wire logic         cmdValid,
  input  wire sep_pkg::sep_cmd_t cmd,
  input  wire logic [2:0]   devSel,
  input  wire logic [7:0]   wordAddr,
  input  wire logic [7:0]   readLen,
  output logic              cmdReady,
  output logic              dataValid,
  output logic [7:0]        dataOut,
  output logic              ackError
);
  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP, M_DONE} sep_mstate_t;
  // a list of byte-level actions; each byte is 9 scl clocks
  sep_mstate_t st_q;
  logic [15:0] div_q;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [8:0]  tx_q;
  logic [7:0]  rx_q;
  logic [7:0]  left_q;
  logic [2:0]  step_q;
  logic        scl_q, sda_q, rd_q;
  logic        sdaS1_q, sdaS2_q;
  logic        tick;

  assign tick = (div_q == 16'(HALF / 2));
  always_ff @(posedge clk) begin
    if (!rst_n || tick) div_q <= 16'h0;
    else div_q <= div_q + 16'h1;
  end
  always_ff @(posedge clk) begin
    sdaS1_q <= bus.sda;
    sdaS2_q <= sdaS1_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= M_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; ph_q <= 2'h0; bit_q <= 4'h0;
      tx_q <= 9'h1FF; rx_q <= 8'h00; left_q <= 8'h00; step_q <= 3'h0; rd_q <= 1'b0;
      cmdReady <= 1'b0; dataValid <= 1'b0; dataOut <= 8'h00; ackError <= 1'b0;
    end else begin
      cmdReady  <= 1'b0;
      dataValid <= 1'b0;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (st_q)
          M_IDLE: if (cmdValid) begin
            st_q <= M_START; ph_q <= 2'h0; step_q <= 3'h0; ackError <= 1'b0;
            left_q <= readLen;
          end
          M_START: begin                                                    // [R19]
            if (ph_q == 2'h0) begin sda_q <= 1'b1; end
            else if (ph_q == 2'h1) scl_q <= 1'b1;
            else if (ph_q == 2'h2) sda_q <= 1'b0;
            else begin
              scl_q <= 1'b0; st_q <= M_BIT; bit_q <= 4'h0;
              if (cmd == sep_pkg::SEP_CMD_RESYNC && step_q == 3'h0) begin
                tx_q <= 9'h1FF; rd_q <= 1'b0;                             // [R12] [R16]
              end else if (cmd == sep_pkg::SEP_CMD_RESYNC) begin
                st_q <= M_STOP;                                             // [R15]
              end else if (cmd == sep_pkg::SEP_CMD_CURRENT || step_q != 3'h0) begin
                tx_q <= {`SEP_TYPE_CODE, devSel, 1'b1, 1'b1}; rd_q <= 1'b0; // [R7]
                step_q <= 3'h3;
              end else begin
                tx_q <= {`SEP_TYPE_CODE, devSel, 1'b0, 1'b1}; rd_q <= 1'b0;
                step_q <= 3'h1;
              end
            end
          end
          M_BIT: begin
            if (ph_q == 2'h0) sda_q <= tx_q[8];
            else if (ph_q == 2'h1) scl_q <= 1'b1;
            else if (ph_q == 2'h2) rx_q <= (bit_q < 4'h8) ? {rx_q[6:0], sdaS2_q} : rx_q;
            else begin
              scl_q <= 1'b0; tx_q <= {tx_q[7:0], 1'b1}; bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                bit_q <= 4'h0;
                if (!rd_q && cmd != sep_pkg::SEP_CMD_RESYNC && sdaS2_q) begin
                  ackError <= 1'b1; st_q <= M_STOP;                        // [R17]
                end else if (cmd == sep_pkg::SEP_CMD_RESYNC) begin
                  st_q <= M_START; step_q <= 3'h1;
                end else if (rd_q) begin
                  dataValid <= 1'b1; dataOut <= rx_q; left_q <= left_q - 8'h1;
                  tx_q <= {8'hFF, (left_q > 8'h2) ? 1'b0 : 1'b1};
                  if (left_q <= 8'h1) st_q <= M_STOP;                       // [R3] [R8]
                end else if (step_q == 3'h1) begin
                  tx_q <= {wordAddr, 1'b1}; step_q <= 3'h2;                 // [R6]
                end else if (step_q == 3'h2 && cmd == sep_pkg::SEP_CMD_WRITE) begin
                  // byte write reuses readLen as the data byte
                  tx_q <= {readLen, 1'b1}; step_q <= 3'h5;
                end else if (step_q == 3'h2) begin
                  st_q <= M_START; step_q <= 3'h4;                          // [R7]
                end else if (step_q == 3'h5) begin
                  st_q <= M_STOP;
                end else begin
                  rd_q <= 1'b1; tx_q <= {8'hFF, (left_q > 8'h1) ? 1'b0 : 1'b1};
                end
              end
            end
          end
          M_STOP: begin                                                     // [R19]
            if (ph_q == 2'h0) sda_q <= 1'b0;
            else if (ph_q == 2'h1) scl_q <= 1'b1;
            else if (ph_q == 2'h2) sda_q <= 1'b1;
            else st_q <= M_DONE;
          end
          M_DONE: begin
            cmdReady <= 1'b1; st_q <= M_IDLE;
          end
          default: st_q <= M_IDLE;
        endcase
      end
    end
  end

  assign bus.sclMasterOut  = 1'b0;
  assign bus.sclMasterOe_n = scl_q;
  assign bus.sdaMasterOut  = 1'b0;
  assign bus.sdaMasterOe_n = sda_q;
endmodule
`default_nettype wire

// ===== logic/sep_pkg.sv
// sep_pkg.sv: types used by the master end and the bench
// assumes: nothing
package sep_pkg;
  typedef enum logic [2:0] {
    SEP_CMD_CURRENT,
    SEP_CMD_RANDOM,
    SEP_CMD_WRITE,
    SEP_CMD_RESYNC
  } sep_cmd_t;
endpackage

// ===== logic/sep_regs.svh
// sep_regs.svh: constants for the serial eeprom read path and its bus master
// assumes: included by bare name from logic files
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH
// device type code; value arbitrary
`define SEP_TYPE_CODE      4'h6
`define SEP_CLK_MHZ        125
`define SEP_SCL_NS         2560
`define SEP_SCL_HALF       (`SEP_SCL_NS * `SEP_CLK_MHZ / 2000)
`define SEP_WRITE_US       5
`define SEP_WRITE_CYC      (`SEP_WRITE_US * `SEP_CLK_MHZ)
`define SEP_PAGE_BITS      4
`define SEP_DUMMY_CLOCKS   9
`endif

// ===== tb/sep_bus_assertions.sv
// sep_bus_assertions.sv: protocol checks on the two-wire bus between both ends
// assumes: instantiated beside the bus interface, fed its resolved lines
`timescale 1ns/10ps
`default_nettype none
module sep_bus_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaSlaveOut,
  input wire logic sdaSlaveOe_n
);
  // ==========================================
  // frame tracking
  logic       sclLast_q;
  logic       sdaLast_q;
  logic       inFrame_q;
  logic [3:0] bitCnt_q;
  logic [1:0] byteCnt_q;
  logic       startEv;
  logic       stopEv;
  logic       sclRise;

  assign startEv = sclLast_q & scl & sdaLast_q & ~sda;
  assign stopEv  = sclLast_q & scl & ~sdaLast_q & sda;
  assign sclRise = ~sclLast_q & scl;

  always_ff @(posedge clk) begin
    sclLast_q <= rst_n ? scl : 1'b1;
    sdaLast_q <= rst_n ? sda : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || stopEv) begin
      inFrame_q <= 1'b0;
    end else if (startEv) begin
      inFrame_q <= 1'b1;
    end
  end

  // bit count per byte, 9 clocks with the acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n || startEv || stopEv) begin
      bitCnt_q <= 4'h0;
    end else if (sclRise) begin
      bitCnt_q <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || startEv || stopEv) begin
      byteCnt_q <= 2'h0;
    end else if (sclRise && bitCnt_q == 4'h8 && byteCnt_q != 2'h3) begin
      byteCnt_q <= byteCnt_q + 2'h1;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pull_only_low: assert property (!sdaSlaveOut)
    else $error("eeprom data output not low");
  a_no_high_drive: assert property (!sdaSlaveOe_n |-> !sda)
    else $error("data line high while eeprom pulls it");
  a_slave_edge_low: assert property ($changed(sdaSlaveOe_n) |-> !scl)
    else $error("eeprom changed data line while clock high");
  a_stop_release: assert property (stopEv |-> sdaSlaveOe_n [*8])
    else $error("eeprom drives data line after stop");
  a_start_release: assert property (startEv |-> sdaSlaveOe_n [*4])
    else $error("eeprom drives data line right after start");
  a_ack_ninth_bit: assert property (sclRise && !sdaSlaveOe_n && byteCnt_q == 2'h0 |-> bitCnt_q == 4'h8)
    else $error("eeprom pulls low outside the address acknowledge");
  // one clock rises between the ninth bit and a repeated start
  a_restart_boundary: assert property (startEv && inFrame_q |-> bitCnt_q == 4'h1)
    else $error("repeated start not on a byte boundary");
  a_stop_boundary: assert property (stopEv && inFrame_q |-> bitCnt_q inside {4'h0, 4'h1})
    else $error("stop not on a byte boundary");

  c_restart: cover property (startEv && inFrame_q);
  c_slave_ack: cover property (sclRise && !sdaSlaveOe_n && byteCnt_q == 2'h0);
  c_stop_frame: cover property (stopEv && inFrame_q && byteCnt_q != 2'h0);
endmodule
`default_nettype wire

// ===== tb/serial_eeprom_read_path_test.sv
// serial_eeprom_read_path_test.sv: master end driving the eeprom end across the bus
// assumes: eeprom content unknown until the bench writes it
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_read_path_test;
  logic              clk;
  logic              rst_n;
  logic              cmdValid;
  sep_pkg::sep_cmd_t cmd;
  logic [2:0]        devSel;
  logic [7:0]        wordAddr;
  logic [7:0]        readLen;
  logic              cmdReady;
  logic              dataValid;
  logic [7:0]        dataOut;
  logic              ackError;
  logic [2:0]        selPins;
  logic              lowSupply;
  logic              writeProtect;
  logic              writeBusy;
  logic              writeCancelled;
  logic [7:0]        rxQ[$];
  int                nFail;
  int                checked;

  sep_bus_if bus ();

  sep_master #(.HALF(16)) sep_master_inst (
    .clk(clk), .rst_n(rst_n), .bus(bus), .cmdValid(cmdValid), .cmd(cmd), .devSel(devSel),
    .wordAddr(wordAddr), .readLen(readLen), .cmdReady(cmdReady), .dataValid(dataValid),
    .dataOut(dataOut), .ackError(ackError));

  sep_eeprom #(.ADDR_W(8), .WRITE_CYC(600)) sep_eeprom_inst (
    .clk(clk), .rst_n(rst_n), .bus(bus), .addr_select_bit0_pin(selPins[0]),
    .addr_select_bit1_pin(selPins[1]), .addr_select_bit2_pin(selPins[2]), .lowSupply(lowSupply),
    .writeProtect(writeProtect), .writeBusy(writeBusy), .writeCancelled(writeCancelled));

  sep_bus_assertions sep_bus_assertions_inst (
    .clk(clk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda), .sdaSlaveOut(bus.sdaSlaveOut),
    .sdaSlaveOe_n(bus.sdaSlaveOe_n));

  // ==========================================
  // clock, capture and checks
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dataValid === 1'b1) begin
      rxQ.push_back(dataOut);
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one command, held until the master reports it done
  task automatic run(input sep_pkg::sep_cmd_t c, input logic [2:0] s, input logic [7:0] a, input logic [7:0] n);
    int i;
    rxQ.delete();
    @(posedge clk);
    cmd      <= c;
    devSel   <= s;
    wordAddr <= a;
    readLen  <= n;
    cmdValid <= 1'b1;
    for (i = 0; i < 20000; i++) begin
      @(posedge clk);
      if (cmdReady === 1'b1) break;
    end
    cmdValid <= 1'b0;
    check("command done", 8'(i < 20000), 8'h01);
  endtask

  // byte write, then wait out the write cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    run(sep_pkg::SEP_CMD_WRITE, 3'h5, a, d);
    repeat (700) @(posedge clk);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    nFail++;
    closeOut();
  end

  // ==========================================
  // scenarios
  initial begin
    rst_n        = 1'b0;
    cmdValid     = 1'b0;
    cmd          = sep_pkg::SEP_CMD_CURRENT;
    devSel       = 3'h0;
    wordAddr     = 8'h00;
    readLen      = 8'h01;
    selPins      = 3'h5;
    lowSupply    = 1'b0;
    writeProtect = 1'b0;
    nFail        = 0;
    checked      = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    run(sep_pkg::SEP_CMD_RESYNC, 3'h5, 8'h00, 8'h01);
    check("resync ack error", 8'(ackError), 8'h00);
    check("resync bytes", 8'(rxQ.size()), 8'h00);
    run(sep_pkg::SEP_CMD_WRITE, 3'h5, 8'h10, 8'h3C);
    check("write ack error", 8'(ackError), 8'h00);
    check("write busy", 8'(writeBusy), 8'h01);
    run(sep_pkg::SEP_CMD_CURRENT, 3'h5, 8'h00, 8'h01);
    check("busy ack error", 8'(ackError), 8'h01);
    check("busy bytes", 8'(rxQ.size()), 8'h00);
    repeat (700) @(posedge clk);
    check("write done", 8'(writeBusy), 8'h00);
    check("write cancelled", 8'(writeCancelled), 8'h00);
    wr(8'h11, 8'hA5);
    wr(8'hFF, 8'h5A);
    wr(8'h00, 8'hC3);
    run(sep_pkg::SEP_CMD_RANDOM, 3'h5, 8'h10, 8'h02);
    check("random ack error", 8'(ackError), 8'h00);
    check("sequential bytes", 8'(rxQ.size()), 8'h02);
    check("random first byte", rxQ[0], 8'h3C);
    check("sequential byte", rxQ[1], 8'hA5);
    run(sep_pkg::SEP_CMD_RANDOM, 3'h5, 8'h10, 8'h01);
    run(sep_pkg::SEP_CMD_CURRENT, 3'h5, 8'h00, 8'h01);
    check("current after read", rxQ[0], 8'hA5);
    run(sep_pkg::SEP_CMD_RANDOM, 3'h5, 8'hFF, 8'h02);
    check("top byte", rxQ[0], 8'h5A);
    check("wrap to zero", rxQ[1], 8'hC3);
    lowSupply <= 1'b1;
    run(sep_pkg::SEP_CMD_WRITE, 3'h5, 8'h10, 8'h77);
    lowSupply <= 1'b0;
    check("low supply cancel", 8'(writeCancelled), 8'h01);
    check("low supply busy", 8'(writeBusy), 8'h00);
    writeProtect <= 1'b1;
    run(sep_pkg::SEP_CMD_WRITE, 3'h5, 8'h11, 8'h99);
    writeProtect <= 1'b0;
    check("protect data ack", 8'(ackError), 8'h01);
    run(sep_pkg::SEP_CMD_RANDOM, 3'h5, 8'h10, 8'h02);
    check("cancelled write kept", rxQ[0], 8'h3C);
    check("protected write kept", rxQ[1], 8'hA5);
    run(sep_pkg::SEP_CMD_RANDOM, 3'h2, 8'h10, 8'h01);
    check("foreign select ack", 8'(ackError), 8'h01);
    check("foreign select bytes", 8'(rxQ.size()), 8'h00);
    for (int p = 0; p < 8; p++) begin
      selPins <= 3'(p);
      run(sep_pkg::SEP_CMD_RANDOM, 3'(p), 8'h11, 8'h01);
      check("select pins ack", 8'(ackError), 8'h00);
      check("select pins bytes", 8'(rxQ.size()), 8'h01);
      check("select pins data", rxQ[0], 8'hA5);
    end
    closeOut();
  end
endmodule
`default_nettype wire
